// file: emsdp_defines.svh
// Purpose: constants of the extension metadata packet transmitter
// Assumes: byte-addressed register port, 32-bit data
// Notes: offsets are byte addresses
`ifndef EMSDP_DEFINES_SVH
`define EMSDP_DEFINES_SVH
`define EMSDP_OFS_CTL0 8'h00
`define EMSDP_OFS_CTL1 8'h04
`define EMSDP_OFS_WIN0 8'h08
`define EMSDP_OFS_WIN1 8'h0C
`define EMSDP_OFS_CONF 8'h10
`define EMSDP_OFS_HDR 8'h14
`define EMSDP_OFS_MISC 8'h18
`define EMSDP_BIT_AUTOINC 14
`define EMSDP_BIT_READY 16
`define EMSDP_BIT_EMPTY 24
`define EMSDP_BIT_CHAIN_DONE 31
`define EMSDP_BIT_BLOCK_MODE 22
`define EMSDP_BIT_ENABLE 0
`define EMSDP_BIT_AUDIO 1
`define EMSDP_PKT_DWORDS 4'h8
`define EMSDP_HDR_DWORDS 4'h1
`define EMSDP_CONF_RST 32'h0000_0000
`define EMSDP_HDR_RST 32'h0000_0000
`endif

// file: emsdp_pkg.sv
// Purpose: types of the extension metadata packet transmitter
// Assumes: nothing beyond the defines header
// Notes: link word carries one doubleword of a packet
package emsdp_pkg;
  typedef struct packed {
    logic valid;
    logic sop;
    logic eop;
    logic [31:0] data;
  } emsdp_link_t;
  typedef enum logic [1:0] {
    EMSDP_IDLE = 2'b00,
    EMSDP_HEAD = 2'b01,
    EMSDP_BODY = 2'b10
  } emsdp_state_t;
endpackage

// file: emsdp_tx.sv
// Purpose: sends frame-synchronous metadata packets in vertical blanking
// Assumes: video timing inputs are on i_clk_sys; sink accepts one word a cycle
// Notes: two ping-pong buffers of 256 doublewords each
`timescale 1ns/1ps
`include "emsdp_defines.svh"
module emsdp_tx #(
  parameter int IDX_W = 8
) (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic i_vblank,
  input wire logic i_hblank,
  output emsdp_pkg::emsdp_link_t o_link
);
  import emsdp_pkg::*;
  // Register map seen by software, byte offsets on i_addr
  //   control 0/1 : [7:0] write index, loaded when bit 14 is written 0
  //                 [14] index auto-increment enable
  //                 [16] ready, writing 1 releases the buffer
  //                 [24] empty, read only, set again once drained
  //   window 0/1  : write-only data window into the buffer, reads as 0
  //   chain config: [9:0] packets per chain, [31] chain done, read only
  //                 a write to it clears done and the sent count; a packet ending outside block mode in the same cycle still counts and can set done
  //   header      : packet header word used outside block mode
  //   misc        : [0] enable, [1] audio enabled, [22] block mode
  // Unmapped reads return zero, unmapped writes are dropped.
  //
  // Link timing, register header mode:
  //   start edge, then header word with sop, then eight buffer words,
  //   the last one with eop.
  // Link timing, block mode:
  //   start edge, one quiet cycle, then nine buffer words, the first
  //   with sop and the last with eop.
  // At least one quiet cycle always follows an eop, so the sink can
  // rely on sop only after a gap.
  //
  // Each buffer holds 256 words, 255 of them usable: 31 bare packets of eight words or 28
  // packets of nine words with their header
  // Two full buffers carry up to 2K bytes of metadata per frame
  localparam int DEPTH = 1 << IDX_W;
  logic [31:0] mem0 [DEPTH];
  logic [31:0] mem1 [DEPTH];
  logic [IDX_W-1:0] wr_ptr_ff [2];
  logic [IDX_W-1:0] rd_ptr_ff [2];
  logic [1:0] autoinc_ff;
  logic [1:0] ready_ff;
  logic [1:0] empty_ff;
  logic [9:0] pkt_count_ff;
  logic [9:0] pkt_sent_ff;
  logic chain_done_ff;
  logic [31:0] hdr_ff;
  logic block_mode_ff;
  logic enable_ff;
  logic audio_ff;
  logic cur_ff;
  logic [3:0] dw_ff;
  emsdp_state_t state_ff;
  emsdp_link_t link_ff;
  logic [31:0] rdata_ff;
  logic [31:0] rd_word;
  logic [3:0] pkt_len;
  logic window_ok;
  logic start_ok;
  logic buf_ok;
  logic room_ok;
  logic gap_ok;
  logic [1:0] win_wr;
  logic [1:0] ctl_wr;
  logic last_dw;
  logic buf_last;

  // One-hot select of a per-buffer register pair
  function automatic logic [1:0] sel2(input logic [7:0] a,
                                      input logic [7:0] b0,
                                      input logic [7:0] b1);
    sel2 = {a == b1, a == b0};
  endfunction

  // Write decode for the paired registers
  assign win_wr = i_wr ? sel2(i_addr, `EMSDP_OFS_WIN0, `EMSDP_OFS_WIN1) : 2'b00;
  assign ctl_wr = i_wr ? sel2(i_addr, `EMSDP_OFS_CTL0, `EMSDP_OFS_CTL1) : 2'b00;

  // Placement window in vblank depends on audio
  assign window_ok = i_vblank && (!audio_ff || !i_hblank);
  // Whole packets only; a packet never starts on a partial group
  assign pkt_len = block_mode_ff ? (`EMSDP_PKT_DWORDS + `EMSDP_HDR_DWORDS)
                                 : `EMSDP_PKT_DWORDS;
  // Current buffer released by software and holding data
  assign buf_ok = ready_ff[cur_ff] && !empty_ff[cur_ff];
  // A whole packet must be present; a short tail waits for the rest
  // rather than leaving as a fragment
  assign room_ok = (wr_ptr_ff[cur_ff] - rd_ptr_ff[cur_ff]) >=
                   IDX_W'(pkt_len);
  // In header mode a start right after eop would glue two packets
  // together on the link, so one quiet cycle is forced
  assign gap_ok = !link_ff.eop;
  // All start conditions together
  assign start_ok = enable_ff && window_ok && buf_ok && room_ok && gap_ok;
  assign rd_word = cur_ff ? mem1[rd_ptr_ff[1]] : mem0[rd_ptr_ff[0]];
  assign last_dw = dw_ff == (pkt_len - 4'h1);
  assign buf_last = (rd_ptr_ff[cur_ff] + IDX_W'(1)) == wr_ptr_ff[cur_ff];

  // Buffer storage, no reset needed for data
  always_ff @(posedge i_clk_sys) begin
    if (win_wr[0]) begin
      mem0[wr_ptr_ff[0]] <= i_wdata;
    end
    if (win_wr[1]) begin
      mem1[wr_ptr_ff[1]] <= i_wdata;
    end
  end

  // Per-buffer control, pointers and flags
  // Limitation: the read pointer only chases the write pointer, so a
  // buffer filled past 255 entries wraps and looks short; software
  // must stay within one buffer's worth before setting ready.
  // A drain in the same cycle as a ready write wins; software only
  // sets ready after seeing empty, so this case is not expected.
  for (genvar b = 0; b < 2; b++) begin : g_buf
    logic rd_step;
    assign rd_step = (state_ff != EMSDP_IDLE) && (cur_ff == 1'(b));
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
        wr_ptr_ff[b] <= '0;
        rd_ptr_ff[b] <= '0;
        autoinc_ff[b] <= 1'b0;
        ready_ff[b] <= 1'b0;
        empty_ff[b] <= 1'b1;
      end else begin
        // Without auto-increment software sets the index itself
        if (ctl_wr[b]) begin
          autoinc_ff[b] <= i_wdata[`EMSDP_BIT_AUTOINC];
          if (!i_wdata[`EMSDP_BIT_AUTOINC]) begin
            wr_ptr_ff[b] <= i_wdata[IDX_W-1:0];
          end
          if (i_wdata[`EMSDP_BIT_READY]) begin
            ready_ff[b] <= 1'b1;
          end
        end else if (win_wr[b]) begin
          empty_ff[b] <= 1'b0;
          if (autoinc_ff[b]) begin
            wr_ptr_ff[b] <= wr_ptr_ff[b] + IDX_W'(1); // Wraps
          end
        end
        // Reads start at entry zero and run until pointers match
        if (rd_step) begin
          rd_ptr_ff[b] <= rd_ptr_ff[b] + IDX_W'(1);
          if (buf_last && last_dw) begin
            // Drained: hand buffer back
            ready_ff[b] <= 1'b0;
            empty_ff[b] <= 1'b1;
            rd_ptr_ff[b] <= '0;
            wr_ptr_ff[b] <= '0;
          end
        end
      end
    end
  end

  // Packet sequencer; drains current buffer then moves to the other
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_ff <= EMSDP_IDLE;
      cur_ff <= 1'b0;
      dw_ff <= 4'h0;
    end else begin
      unique case (state_ff)
        EMSDP_IDLE: begin
          dw_ff <= 4'h0;
          if (start_ok) begin
            state_ff <= EMSDP_HEAD;
          end else if (!ready_ff[cur_ff] && ready_ff[~cur_ff]) begin
            cur_ff <= ~cur_ff; // Ping-pong continuation
          end
        end
        EMSDP_HEAD, EMSDP_BODY: begin
          dw_ff <= dw_ff + 4'h1;
          state_ff <= EMSDP_BODY;
          if (last_dw) begin
            state_ff <= EMSDP_IDLE;
            dw_ff <= 4'h0;
            if (buf_last) begin
              cur_ff <= ~cur_ff;
            end
          end
        end
        default: state_ff <= EMSDP_IDLE;
      endcase
    end
  end

  // Link output; header word prepended from register unless in block mode
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      link_ff <= '0;
    end else begin
      link_ff.valid <= 1'b0;
      link_ff.sop <= 1'b0;
      link_ff.eop <= 1'b0;
      if (state_ff == EMSDP_IDLE && start_ok && !block_mode_ff) begin
        link_ff.valid <= 1'b1;
        link_ff.sop <= 1'b1;
        link_ff.data <= hdr_ff;
      end else if (state_ff != EMSDP_IDLE) begin
        link_ff.valid <= 1'b1;
        link_ff.sop <= block_mode_ff && dw_ff == 4'h0;
        link_ff.eop <= last_dw;
        link_ff.data <= rd_word;
      end
    end
  end
  assign o_link = link_ff;

  // Chain accounting; done set wins over software clear
  // Only header-register mode counts packets; in block mode the chain
  // length is carried by the buffer contents, so done is not set there.
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pkt_count_ff <= 10'(`EMSDP_CONF_RST);
      pkt_sent_ff <= 10'h000;
      chain_done_ff <= 1'b0;
    end else begin
      if (i_wr && i_addr == `EMSDP_OFS_CONF) begin
        pkt_count_ff <= i_wdata[9:0];
        pkt_sent_ff <= 10'h000;
        chain_done_ff <= 1'b0;
      end
      if (state_ff != EMSDP_IDLE && last_dw && !block_mode_ff) begin
        pkt_sent_ff <= pkt_sent_ff + 10'h001;
        if (pkt_sent_ff + 10'h001 == pkt_count_ff) begin
          chain_done_ff <= 1'b1;
        end
      end
    end
  end

  // Header, misc control registers
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      hdr_ff <= `EMSDP_HDR_RST;
      block_mode_ff <= 1'b0;
      enable_ff <= 1'b0;
      audio_ff <= 1'b0;
    end else if (i_wr) begin
      if (i_addr == `EMSDP_OFS_HDR) begin
        hdr_ff <= i_wdata;
      end
      if (i_addr == `EMSDP_OFS_MISC) begin
        block_mode_ff <= i_wdata[`EMSDP_BIT_BLOCK_MODE];
        enable_ff <= i_wdata[`EMSDP_BIT_ENABLE];
        audio_ff <= i_wdata[`EMSDP_BIT_AUDIO];
      end
    end
  end

  // Read data one cycle after strobe; unmapped reads as zero
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rdata_ff <= 32'h0000_0000;
    end else begin
      rdata_ff <= 32'h0000_0000;
      if (i_rd) begin
        for (int b = 0; b < 2; b++) begin
          if (sel2(i_addr, `EMSDP_OFS_CTL0, `EMSDP_OFS_CTL1) == 2'(1 << b)) begin
            rdata_ff[IDX_W-1:0] <= wr_ptr_ff[b];
            rdata_ff[`EMSDP_BIT_AUTOINC] <= autoinc_ff[b];
            rdata_ff[`EMSDP_BIT_READY] <= ready_ff[b];
            rdata_ff[`EMSDP_BIT_EMPTY] <= empty_ff[b];
          end
        end
        if (i_addr == `EMSDP_OFS_CONF) begin
          rdata_ff[9:0] <= pkt_count_ff;
          rdata_ff[`EMSDP_BIT_CHAIN_DONE] <= chain_done_ff;
        end
        if (i_addr == `EMSDP_OFS_HDR) begin
          rdata_ff <= hdr_ff;
        end
        if (i_addr == `EMSDP_OFS_MISC) begin
          rdata_ff[`EMSDP_BIT_BLOCK_MODE] <= block_mode_ff;
          rdata_ff[`EMSDP_BIT_ENABLE] <= enable_ff;
          rdata_ff[`EMSDP_BIT_AUDIO] <= audio_ff;
        end
      end
    end
  end
  assign o_rdata = rdata_ff;
endmodule // emsdp_tx

// file: emsdp_tx_assertions.sv
// Purpose: port level checks of the metadata packet transmitter
// Assumes: one clock domain, reset asynchronous and active high
// Notes: shadows misc and header writes to judge packet starts
`timescale 1ns/1ps
module emsdp_tx_assertions (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic i_vblank,
  input wire logic i_hblank,
  input wire emsdp_pkg::emsdp_link_t o_link
);
  import emsdp_pkg::*;
  logic audio_ff;
  logic block_ff;
  logic [31:0] hdr_ff;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  // Shadow copies; the design's own copies are not visible here
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      audio_ff <= 1'b0;
      block_ff <= 1'b0;
      hdr_ff <= 32'h0000_0000;
    end else if (i_wr) begin
      if (i_addr == 8'h18) begin
        audio_ff <= i_wdata[1];
        block_ff <= i_wdata[22];
      end
      if (i_addr == 8'h14) begin
        hdr_ff <= i_wdata;
      end
    end
  end
  sequence s_start;
    o_link.valid && o_link.sop;
  endsequence
  sequence s_body;
    (o_link.valid && !o_link.eop)[*8] ##1 (o_link.valid && o_link.eop);
  endsequence
  property p_len;
    s_start |-> s_body;
  endproperty
  a_len: assert property (p_len) else $error("packet not nine words");
  property p_cont;
    o_link.valid && !o_link.sop |-> $past(o_link.valid);
  endproperty
  a_cont: assert property (p_cont) else $error("word outside packet");
  property p_gap;
    o_link.valid && o_link.eop |=> !o_link.valid;
  endproperty
  a_gap: assert property (p_gap) else $error("no idle after packet");
  property p_vblank;
    s_start |-> (block_ff ? $past(i_vblank, 2) : $past(i_vblank));
  endproperty
  a_vblank: assert property (p_vblank) else $error("start outside vblank");
  property p_audio;
    o_link.valid && o_link.sop && audio_ff
      |-> !(block_ff ? $past(i_hblank, 2) : $past(i_hblank));
  endproperty
  a_audio: assert property (p_audio) else $error("start in hblank");
  property p_hdr;
    o_link.valid && o_link.sop && !block_ff |-> o_link.data == hdr_ff;
  endproperty
  a_hdr: assert property (p_hdr) else $error("header word wrong");
  property p_rd_idle;
    !$past(i_rd) |-> o_rdata == 32'h0000_0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_win_wo;
    $past(i_rd) && ($past(i_addr) == 8'h08 || $past(i_addr) == 8'h0C)
      |-> o_rdata == 32'h0000_0000;
  endproperty
  a_win_wo: assert property (p_win_wo) else $error("window read not zero");
endmodule // emsdp_tx_assertions
bind emsdp_tx emsdp_tx_assertions emsdp_tx_assertions_i (.i_clk_sys,
  .i_sys_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_vblank,
  .i_hblank, .o_link);

// file: emsdp_sink.sv
// Purpose: display sink end of the metadata link
// Assumes: the sink takes one word every cycle
// Notes: words are logged in arrival order for the bench
`timescale 1ns/1ps
module emsdp_sink (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire emsdp_pkg::emsdp_link_t i_link
);
  import emsdp_pkg::*;
  logic [31:0] got_ff [$];
  // Log every valid word; the link gives the sink no way to stall
  always @(posedge i_clk_sys) begin
    if (!i_sys_rst && i_link.valid === 1'b1) begin
      got_ff.push_back(i_link.data);
    end
  end
endmodule // emsdp_sink

// file: emsdp_tx_tb_top.sv
// Purpose: register level tests of the metadata packet transmitter
// Assumes: bench drives inputs by non-blocking assignment at posedge
// Notes: sink model logs link words; link checks compare against that log
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_fail++; \
  $display("BAD %0t got %h exp %h", $time, a, e); end end
module emsdp_tx_tb_top;
  import emsdp_pkg::*;
  localparam logic [31:0] HDR = 32'hA5A5_0001;
  logic i_clk_sys, i_sys_rst, i_wr, i_rd, i_vblank, i_hblank;
  logic [7:0] i_addr;
  logic [31:0] i_wdata, o_rdata, rd_val;
  emsdp_link_t o_link;
  int n_fail = 0;
  int checks_done = 0;
  int cyc = 0;
  emsdp_tx emsdp_tx_i (.i_clk_sys, .i_sys_rst, .i_addr, .i_wdata, .i_wr,
    .i_rd, .o_rdata, .i_vblank, .i_hblank, .o_link);
  emsdp_sink emsdp_sink_i (.i_clk_sys, .i_sys_rst, .i_link(o_link));
  // 40 MHz clock
  initial begin
    i_clk_sys = 1'b0;
    forever #12.5 i_clk_sys = ~i_clk_sys;
  end
  // Hang guard; the tests need well under a thousand cycles
  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    if (n_fail == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e, m);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1 rd_val = o_rdata;
    `CHK(rd_val & m, e)
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask
  task automatic wait_words(input int n);
    for (int k = 0; k < 60 && emsdp_sink_i.got_ff.size() < n; k++)
      @(posedge i_clk_sys);
  endtask
  initial begin
    i_sys_rst = 1'b1;
    {i_wr, i_rd, i_vblank, i_hblank, i_addr, i_wdata} = '0;
    repeat (5) @(posedge i_clk_sys);
    i_sys_rst <= 1'b0;
    chk_rd(8'h00, 32'h0100_0000, 32'h0101_0000);
    chk_rd(8'h40, 32'h0000_0000, 32'hFFFF_FFFF);
    // Header from register, buffer zero, auto-increment, audio on
    wr(8'h18, 32'h0000_0003);
    wr(8'h10, 32'h0000_0001);
    wr(8'h14, HDR);
    wr(8'h00, 32'h0000_4000);
    for (int i = 0; i < 8; i++) wr(8'h08, 32'h1000_0000 + i);
    chk_rd(8'h08, 32'h0000_0000, 32'hFFFF_FFFF);
    wr(8'h00, 32'h0001_4000);
    idle(20);
    `CHK(emsdp_sink_i.got_ff.size(), 0)
    i_vblank <= 1'b1;
    i_hblank <= 1'b1;
    idle(20);
    `CHK(emsdp_sink_i.got_ff.size(), 0)
    i_hblank <= 1'b0;
    wait_words(9);
    `CHK(emsdp_sink_i.got_ff[0], HDR)
    for (int i = 0; i < 8; i++)
      `CHK(emsdp_sink_i.got_ff[i + 1], 32'h1000_0000 + i)
    chk_rd(8'h00, 32'h0100_0000, 32'h0101_0000);
    chk_rd(8'h10, 32'h8000_0001, 32'h8000_03FF);
    // Header in buffer one, indexed writes, audio off, sent in hblank
    i_vblank <= 1'b0;
    wr(8'h18, 32'h0040_0001);
    for (int i = 0; i < 9; i++) begin
      wr(8'h04, i);
      wr(8'h0C, 32'h2000_0000 + i);
    end
    wr(8'h04, 32'h0001_0009);
    i_vblank <= 1'b1;
    i_hblank <= 1'b1;
    wait_words(18);
    for (int i = 0; i < 9; i++)
      `CHK(emsdp_sink_i.got_ff[i + 9], 32'h2000_0000 + i)
    chk_rd(8'h04, 32'h0100_0000, 32'h0101_0000);
    // Half a packet must never leave the block
    wr(8'h00, 32'h0000_4000);
    for (int i = 0; i < 4; i++) wr(8'h08, 32'h3000_0000 + i);
    wr(8'h00, 32'h0001_4000);
    idle(30);
    `CHK(emsdp_sink_i.got_ff.size(), 18)
    chk_rd(8'h00, 32'h0000_0000, 32'h0100_0000);
    print_verdict();
  end
endmodule // emsdp_tx_tb_top
